// ===== bench/dxr_per_model.sv
`timescale 1ns/10ps

// outside peripheral: request pin plus data lane toward the engine
module dxr_per_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] hold,
    input wire logic slow,
    input wire logic grant_n,
    input wire logic ready,
    output logic req,
    output logic [7:0] data,
    output logic valid,
    output logic [7:0] sent
);
    logic [7:0] cnt_r;
    logic done_r;

    // request held until granted, dropped hold+1 granted cycles in
    assign req = start & ~done_r;

    // grant age counter and drop flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= 8'h00;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r <= grant_n ? 8'h00 : cnt_r + 8'h01;
            if (!start)
                done_r <= 1'b0;
            else if (!grant_n && cnt_r == hold)
                done_r <= 1'b1;
        end
    end

    // idle lane shows the inverse, so stale data never looks valid
    assign data = valid ? sent : ~sent;

    // counting data, one gap cycle after each beat when slow
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sent <= 8'h00;
            valid <= 1'b0;
        end
        else
        begin
            if (valid && ready)
                sent <= sent + 8'h01;
            valid <= slow ? !(valid && ready) : 1'b1;
        end
    end
endmodule

// ===== bench/tb.sv
`timescale 1ns/10ps

module tb;
    import dxr_pkg::*;
    localparam int BLEN = 10;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] src = 4'h0;
    logic [3:0] ren = 4'hF;
    logic [3:0] chan_active_bit = 4'hF;
    logic [3:0] ireq = 4'h0;
    logic mrdy = 1'b1;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic [7:0] hold = 8'h00;
    logic ext_req, per_valid, per_ready, mem_valid, grant_n, b_act, b_ext, was_act;
    logic [7:0] per_data, mem_data, sent;
    logic [1:0] b_ch;
    int miscompares = 0;
    int comparisons = 0;
    int glen = 0;
    int last_glen = 0;
    logic [7:0] got[$];
    logic [2:0] hist[$];

    always #5 clk = ~clk;

    dxr_ext_req #(.BURST_LEN(BLEN)) dut_u
    (
        .CLK(clk), .SYS_RST(sys_rst), .EXT_REQ(ext_req), .REQUEST_SOURCE_SELECT(src),
        .REQ_ENABLE(ren), .CHAN_ACTIVE_BIT(chan_active_bit), .INT_REQ(ireq), .PER_DATA(per_data),
        .PER_VALID(per_valid), .PER_READY(per_ready), .MEM_DATA(mem_data), .MEM_VALID(mem_valid),
        .MEM_READY(mrdy), .EXT_GRANT_N(grant_n), .BURST_ACTIVE(b_act), .BURST_EXT(b_ext), .BURST_CH(b_ch)
    );

    dxr_per_model per_u
    (
        .clk(clk), .rst(sys_rst), .start(start), .hold(hold), .slow(slow), .grant_n(grant_n),
        .ready(per_ready), .req(ext_req), .data(per_data), .valid(per_valid), .sent(sent)
    );

    // logs words to memory, grant widths and each burst as {ext, channel}
    always @(posedge clk)
    begin
        if (mem_valid === 1'b1 && mrdy) got.push_back(mem_data);
        if (grant_n === 1'b0) glen = glen + 1;
        else begin if (glen > 0) last_glen = glen; glen = 0; end
        if (b_act === 1'b1 && was_act !== 1'b1) hist.push_back({b_ext, b_ch});
        was_act = b_act;
    end

    task automatic stop_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_bit(input logic g, input logic e, input string msg);
        comparisons++;
        if (g !== e) begin miscompares++; $display("[FAIL] %0t %s", $time, msg); end
    endtask

    task automatic chk_val(input logic [7:0] g, input logic [7:0] e, input string msg);
        comparisons++;
        if (g !== e) begin miscompares++; $display("[FAIL] %0t %s %h/%h", $time, msg, g, e); end
    endtask

    // bounded wait for n logged bursts, optionally until the engine is idle
    task automatic wait_hist(input int n, input bit quiet);
        int i;
        for (i = 0; i < 3000 && !(hist.size() >= n && (!quiet || (b_act === 1'b0 && grant_n === 1'b1))); i++)
            @(negedge clk);
        if (i == 3000) begin miscompares++; $display("[FAIL] %0t wait ran out", $time); stop_test(); end
    endtask

    task automatic chk_words(input logic [7:0] base);
        chk_val(8'(got.size()), 8'(BLEN), "word count");
        foreach (got[i]) chk_val(got[i], base + 8'(i), "word order");
        got.delete();
    endtask

    task automatic s_reset();
        chk_bit(grant_n, 1'b1, "grant idle high");
        chk_bit(b_act, 1'b0, "no burst at reset");
        chk_bit(per_ready, 1'b0, "lane closed at reset");
    endtask

    task automatic s_single();
        logic [7:0] base;
        int n0;
        base = sent; n0 = hist.size();
        src = 4'h1; hold = 8'h00; start = 1'b1;
        wait_hist(n0 + 1, 1'b1);
        repeat (30) @(negedge clk);
        chk_val(8'(hist.size() - n0), 8'h01, "one burst");
        chk_val(8'(hist[n0]), 8'h04, "external burst ch0");
        chk_bit(last_glen >= 8, 1'b1, "grant too short");
        chk_words(base);
        start = 1'b0;
        // let the peripheral see the drop before the next request
        repeat (2) @(negedge clk);
    endtask

    task automatic s_stall();
        logic [7:0] base;
        int n0;
        base = sent; n0 = hist.size();
        mrdy = 1'b0; slow = 1'b1; start = 1'b1;
        repeat (60) @(negedge clk);
        chk_bit(per_ready, 1'b0, "full buffer refuses");
        chk_bit(grant_n, 1'b0, "burst waits for room");
        chk_val(sent - base, 8'h09, "buffer and output stage hold nine");
        mrdy = 1'b1;
        wait_hist(n0 + 1, 1'b1);
        repeat (20) @(negedge clk);
        chk_words(base);
        slow = 1'b0; start = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic s_disabled();
        int n0;
        for (int k = 0; k < 3; k++)
        begin
            n0 = hist.size();
            src = (k == 0) ? 4'h0 : 4'h1;
            ren = (k == 1) ? 4'hE : 4'hF;
            chan_active_bit = (k == 2) ? 4'hE : 4'hF;
            start = 1'b1;
            repeat (30) @(negedge clk);
            chk_bit(grant_n, 1'b1, "grant while disabled");
            chk_val(8'(hist.size() - n0), 8'h00, "burst while disabled");
            start = 1'b0;
            repeat (10) @(negedge clk);
        end
        ren = 4'hF; chan_active_bit = 4'hF;
    endtask

    task automatic s_priority();
        logic [7:0] base;
        int n0;
        base = sent; n0 = hist.size();
        src = 4'h4; ireq = 4'h2; start = 1'b1;
        wait_hist(n0 + 1, 1'b0);
        ireq = 4'h0;
        chk_val(8'(hist[n0]), 8'h01, "internal ch1 first");
        chk_bit(grant_n, 1'b1, "no grant on internal burst");
        wait_hist(n0 + 2, 1'b1);
        chk_val(8'(hist[n0 + 1]), 8'h06, "external ch2 next");
        repeat (20) @(negedge clk);
        chk_words(base);
        start = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic s_demote();
        int n0;
        n0 = hist.size();
        src = 4'h1; hold = 8'hFF; start = 1'b1;
        wait_hist(n0 + 1, 1'b0);
        ireq = 4'h8;
        wait_hist(n0 + 3, 1'b0);
        start = 1'b0; ireq = 4'h0;
        wait_hist(n0 + 3, 1'b1);
        repeat (30) @(negedge clk);
        chk_val(8'(hist[n0]), 8'h04, "external ch0 first");
        chk_val(8'(hist[n0 + 1]), 8'h03, "contender ch3 next");
        chk_val(8'(hist[n0 + 2]), 8'h04, "external ch0 again");
        got.delete();
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        s_reset();
        s_single();
        s_stall();
        s_disabled();
        s_priority();
        s_demote();
        stop_test();
    end
endmodule

// ===== pkg/dxr_consts.svh
`ifndef DXR_CONSTS_SVH
`define DXR_CONSTS_SVH

// clock periods, in ns
`define DXR_CLK_PERIOD_NS 10
`define DXR_HCLK_PERIOD_NS 10

// least grant width, in system bus clock periods, and in CLK cycles (rounded up)
`define DXR_MIN_GRANT_HCLK 8
`define DXR_MIN_GRANT_CYC \
    ((`DXR_MIN_GRANT_HCLK * `DXR_HCLK_PERIOD_NS + `DXR_CLK_PERIOD_NS - 1) / `DXR_CLK_PERIOD_NS)

// structure defaults
`define DXR_NUM_CH 4
`define DXR_BURST_LEN 4
`define DXR_DATA_W 8
`define DXR_FIFO_DEPTH 8

`endif

// ===== pkg/dxr_fifo_if.sv
`timescale 1ns/10ps

// carrier between the request engine and its data buffer
interface dxr_fifo_if #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;
    logic [$clog2(DEPTH+1)-1:0] level;

    modport store
    (
        input in_data, in_valid, out_ready,
        output in_ready, out_data, out_valid, level
    );

    modport user
    (
        output in_data, in_valid, out_ready,
        input in_ready, out_data, out_valid, level
    );
endinterface

// ===== pkg/dxr_pkg.sv
package dxr_pkg;

    // burst sequencer states
    typedef enum logic [1:0] {
        DXR_IDLE  = 2'b00,
        DXR_BURST = 2'b01,
        DXR_DONE  = 2'b10
    } dxr_state_e;

endpackage

// ===== rtl/dxr_ext_req.sv
// Behaviour
// - start burst only for highest pending channel, or highest internal one while external is demoted
// - honoured request yields complete burst(s) unless the channel is disabled mid-burst
// - grant only for enabled external-sourced burst
// - request not sampled while grant active
// - external priority lowered when others request
// - grant held at least eight cycles unless the burst is aborted
`timescale 1ns/10ps
`include "dxr_consts.svh"

module dxr_ext_req
    import dxr_pkg::*;
#(
    parameter int NUM_CH = `DXR_NUM_CH,
    parameter int BURST_LEN = `DXR_BURST_LEN,
    parameter int DATA_W = `DXR_DATA_W,
    parameter int FIFO_DEPTH = `DXR_FIFO_DEPTH
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic EXT_REQ,
    input wire logic [NUM_CH-1:0] REQUEST_SOURCE_SELECT,
    input wire logic [NUM_CH-1:0] REQ_ENABLE,
    input wire logic [NUM_CH-1:0] CHAN_ACTIVE_BIT,
    input wire logic [NUM_CH-1:0] INT_REQ,
    input wire logic [DATA_W-1:0] PER_DATA,
    input wire logic PER_VALID,
    output logic PER_READY,
    output logic [DATA_W-1:0] MEM_DATA,
    output logic MEM_VALID,
    input wire logic MEM_READY,
    output logic EXT_GRANT_N,
    output logic BURST_ACTIVE,
    output logic BURST_EXT,
    output logic [$clog2(NUM_CH)-1:0] BURST_CH
);
    localparam int CW = $clog2(NUM_CH);
    localparam int BW = $clog2(BURST_LEN + 1);
    localparam int MIN_GRANT_CYC = `DXR_MIN_GRANT_CYC;
    localparam int GW = $clog2(MIN_GRANT_CYC);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    dxr_state_e state_r;
    dxr_state_e state_nxt;
    logic ext_req_m_r;
    logic ext_req_s_r;
    logic ext_seen_r;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] pref;
    logic [NUM_CH-1:0] pend_q_r;
    logic [CW-1:0] win_ch;
    logic [CW-1:0] cur_ch_r;
    logic cur_ext_r;
    logic cur_ok;
    logic other_req;
    logic demote_r;
    logic start;
    logic abort;
    logic end_burst;
    logic [BW-1:0] beat_cnt_r;
    logic [GW-1:0] cyc_cnt_r;
    logic push;
    logic [BW-1:0] beats_after;
    logic grant_n_r;
    logic per_ready_r;
    logic [DATA_W-1:0] mem_data_r;
    logic mem_valid_r;
    logic [NUM_CH-1:0] below_cur;

    dxr_fifo_if #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) fif ();

    dxr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(CLK),
        .rst(SYS_RST),
        .f(fif)
    );

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ext_req_m_r <= 1'b0;
            ext_req_s_r <= 1'b0;
        end
        else
        begin
            ext_req_m_r <= EXT_REQ;
            ext_req_s_r <= ext_req_m_r;
        end
    end

    // sync output lags pin by two
    a_sync_two_stage: assert property (!$past(SYS_RST) && !$past(SYS_RST, 2) |-> ext_req_s_r == $past(EXT_REQ, 2))
        else $error("request synchroniser is not two stages");

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ext_seen_r <= 1'b0;
        end
        else if (state_r != DXR_BURST)
        begin
            ext_seen_r <= ext_req_s_r;
        end
    end

    a_req_not_sampled: assert property ((state_r == DXR_BURST) && ($past(state_r) == DXR_BURST) |-> $stable(ext_seen_r))
        else $error("request sampled while burst running");

    // per-channel pending terms
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_pend
            assign pend[gi] = REQ_ENABLE[gi] && CHAN_ACTIVE_BIT[gi]
                && (REQUEST_SOURCE_SELECT[gi] ? ext_seen_r : INT_REQ[gi]);
        end
    endgenerate

    assign pref = (demote_r && |(pend & ~REQUEST_SOURCE_SELECT)) ? (pend & ~REQUEST_SOURCE_SELECT) : pend;
    assign other_req = |(pend & ~REQUEST_SOURCE_SELECT);

    // lowest index of preferred set wins
    always_comb
    begin
        win_ch = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (pref[i])
            begin
                win_ch = CW'(i);
            end
        end
    end

    // burst control terms
    assign cur_ok = REQ_ENABLE[cur_ch_r] && CHAN_ACTIVE_BIT[cur_ch_r] && REQUEST_SOURCE_SELECT[cur_ch_r];
    assign start = (state_r == DXR_IDLE) && (|pend);
    assign abort = (state_r == DXR_BURST) && cur_ext_r && !cur_ok;
    // burst ends with all beats done and the minimum grant cycles passed, or on abort
    assign end_burst = (state_r == DXR_BURST)
        && (abort || ((beat_cnt_r == BW'(BURST_LEN)) && (cyc_cnt_r == GW'(MIN_GRANT_CYC - 1))));
    assign push = (state_r == DXR_BURST) && cur_ext_r && per_ready_r && PER_VALID && fif.in_ready;
    assign beats_after = beat_cnt_r + BW'(push);
    assign below_cur = (NUM_CH'(1) << cur_ch_r) - NUM_CH'(1);

    // next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            DXR_IDLE:
            begin
                if (start)
                begin
                    state_nxt = DXR_BURST;
                end
            end
            DXR_BURST:
            begin
                if (end_burst)
                begin
                    state_nxt = DXR_DONE;
                end
            end
            DXR_DONE:
            begin
                state_nxt = DXR_IDLE;
            end
            default:
            begin
                state_nxt = DXR_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_r <= DXR_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // channel latched at burst start
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            cur_ch_r <= '0;
            cur_ext_r <= 1'b0;
            pend_q_r <= '0;
        end
        else
        begin
            pend_q_r <= pend;
            if (start)
            begin
                cur_ch_r <= win_ch;
                cur_ext_r <= REQUEST_SOURCE_SELECT[win_ch];
            end
        end
    end

    // started channel was pending, and highest unless demoted
    a_start_highest: assert property ($rose(state_r == DXR_BURST) |-> pend_q_r[cur_ch_r]
        && ($past(demote_r) || ((pend_q_r & below_cur) == '0)))
        else $error("burst started for a channel that was not highest");

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            beat_cnt_r <= '0;
            cyc_cnt_r <= '0;
        end
        else if (state_r != DXR_BURST)
        begin
            beat_cnt_r <= '0;
            cyc_cnt_r <= '0;
        end
        else
        begin
            if (!cur_ext_r && (beat_cnt_r != BW'(BURST_LEN)))
            begin
                beat_cnt_r <= beat_cnt_r + BW'(1);
            end
            else if (push)
            begin
                beat_cnt_r <= beats_after;
            end
            if (cyc_cnt_r != GW'(MIN_GRANT_CYC - 1))
            begin
                cyc_cnt_r <= cyc_cnt_r + GW'(1);
            end
        end
    end

    // a finished burst carried every beat unless it was aborted
    a_burst_complete: assert property ($rose(state_r == DXR_DONE)
        |-> $past(abort) || ($past(beat_cnt_r) == BW'(BURST_LEN)))
        else $error("burst ended before all beats moved");

    // grant set on external start, released at end
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            grant_n_r <= 1'b1;
        end
        else if (start)
        begin
            grant_n_r <= ~REQUEST_SOURCE_SELECT[win_ch];
        end
        else if (end_burst)
        begin
            grant_n_r <= 1'b1;
        end
    end

    a_grant_idle_high: assert property ((state_r != DXR_BURST) |-> EXT_GRANT_N)
        else $error("grant low outside a burst");

    // grant only for enabled external burst
    a_grant_qualified: assert property (!EXT_GRANT_N |-> (state_r == DXR_BURST) && cur_ext_r
        && ($fell(grant_n_r) || $past(cur_ok)))
        else $error("grant active without a qualified external burst");

    sequence s_grant_start;
        $fell(grant_n_r);
    endsequence

    sequence s_cfg_held;
        cur_ok [*8];
    endsequence

    // grant low for eight cycles at least
    a_grant_min_width: assert property (s_grant_start ##0 s_cfg_held |-> !grant_n_r)
        else $error("grant released before eight cycles");

    // demote after external burst with rivals
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            demote_r <= 1'b0;
        end
        else if (end_burst && cur_ext_r)
        begin
            demote_r <= other_req;
        end
        else if (start)
        begin
            demote_r <= 1'b0;
        end
    end

    sequence s_ext_end_rival;
        end_burst && cur_ext_r && other_req;
    endsequence

    a_demote_next: assert property (s_ext_end_rival |=> demote_r ##1 (state_r == DXR_IDLE))
        else $error("external priority not lowered after contested burst");

    // peripheral ready, registered and conservative
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            per_ready_r <= 1'b0;
        end
        else
        begin
            per_ready_r <= (state_r == DXR_BURST) && cur_ext_r && !end_burst
                && (beats_after < BW'(BURST_LEN))
                && (fif.level + LW'(push) <= LW'(FIFO_DEPTH - 1));
        end
    end

    // fifo fill side, plus drain ready
    assign fif.in_valid = push;
    assign fif.in_data = PER_DATA;
    assign fif.out_ready = !mem_valid_r || MEM_READY;

    // memory-side output stage
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            mem_valid_r <= 1'b0;
            mem_data_r <= '0;
        end
        else if (fif.out_valid && fif.out_ready)
        begin
            mem_valid_r <= 1'b1;
            mem_data_r <= fif.out_data;
        end
        else if (MEM_READY)
        begin
            mem_valid_r <= 1'b0;
        end
    end

    // top outputs, all from flops
    assign PER_READY = per_ready_r;
    assign MEM_DATA = mem_data_r;
    assign MEM_VALID = mem_valid_r;
    assign EXT_GRANT_N = grant_n_r;
    assign BURST_ACTIVE = (state_r == DXR_BURST);
    assign BURST_EXT = cur_ext_r;
    assign BURST_CH = cur_ch_r;
endmodule

// ===== rtl/dxr_fifo.sv
`timescale 1ns/10ps

// synchronous fifo, depth a power of two
module dxr_fifo
    import dxr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst,
    dxr_fifo_if.store f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // handshake terms
    assign f.in_ready = (count_r < (AW+1)'(DEPTH));
    assign f.out_valid = (count_r != '0);
    assign f.out_data = mem[rd_ptr_r];
    assign f.level = count_r;
    assign push = f.in_valid && f.in_ready;
    assign pop = f.out_valid && f.out_ready;

    // storage write
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r] <= f.in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            if (push && !pop)
            begin
                count_r <= count_r + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                count_r <= count_r - (AW+1)'(1);
            end
        end
    end
endmodule
